// ==== bench/event_source.sv ====
// Far-side model: the analog fault and event sources of the status bank.
// Assumes the bench commands a pattern and a hold level on aclk.
`timescale 1ns/100ps
`default_nettype none
module event_source (
   input wire logic aclk,
   input wire logic hold,
   input wire logic [17:0] pattern,
   output logic [17:0] level
);
   // Released sources fall back to inactive, as a cleared analog fault does
   always_ff @(posedge aclk) begin
      level <= hold ? pattern : 18'h00000;
   end
endmodule
`default_nettype wire

// ==== bench/fault_interrupt_status_bank_test.sv ====
// Self-checking bench of the fault and interrupt status bank.
// Assumes the event source model and the bank's config header.
`include "fault_status_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module fault_interrupt_status_bank_test;
   import fault_status_pkg::*;
   logic aclk = 0, aresetn = 0, hold = 0, lat;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, r;
   logic [17:0] pattern = '0, level;
   logic [3:0] wstrb = 4'h1;
   addr_t awaddr = '0, araddr = '0;
   word_t wdata = '0, rdata, d;
   byte_t i, e;
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   logic [33:0] rows [19];
   byte_t regs [7];

   always #10 aclk = ~aclk;

   event_source event_source_i (.aclk(aclk), .hold(hold), .pattern(pattern), .level(level));

   fault_interrupt_status_bank fault_interrupt_status_bank_i (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .ch2_output_short(level[17:16]), .ch2_driver_vgnd(level[15:14]),
      .analog_regulator_short(level[13]), .headset_event(level[12:10]),
      .general_purpose_analog_input_cross(level[9:8]),
      .voice_activity_detector_event(level[7:6]),
      .clock_lock_event(level[5:4]), .ch1_fault(level[3:0]), .irq(irq)
   );

   // ==========================================================
   // Bus and check tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, x);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask

   task automatic wr(input byte_t a, input byte_t v);
      logic done;
      done = 0;
      @(posedge aclk);
      awaddr <= {2'b00, a, 2'b00};
      wdata <= {24'h0, v};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid) begin
            r = bresp;
            bready <= 0;
            done = 1;
         end
      end
   endtask

   task automatic rd(input byte_t a);
      logic done;
      done = 0;
      @(posedge aclk);
      araddr <= {2'b00, a, 2'b00};
      arvalid <= 1;
      rready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 0;
            done = 1;
         end
      end
   endtask

   task automatic rdc(input byte_t a, input byte_t x);
      rd(a);
      chk(d, {24'h0, x});
      chk({30'h0, r}, {30'h0, `RESP_OKAY});
   endtask

   // Six cycles cover the model flop, the two sync flops and the latch
   task automatic src(input logic [17:0] p);
      @(posedge aclk);
      pattern <= p;
      hold <= |p;
      tick(6);
   endtask

   task automatic note(input string s);
      $display("test %s done", s);
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // ==========================================================
   // Sequence
   initial begin
      rows = '{{18'h20000, 8'h39, 8'h80}, {18'h10000, 8'h39, 8'h40},
         {18'h08000, 8'h39, 8'h20}, {18'h04000, 8'h39, 8'h10},
         {18'h02000, 8'h39, 8'h01}, {18'h01000, 8'h3a, 8'h08},
         {18'h00800, 8'h3a, 8'h04}, {18'h00400, 8'h3a, 8'h02},
         {18'h00200, 8'h3b, 8'h80}, {18'h00100, 8'h3b, 8'h40},
         {18'h00080, 8'h3b, 8'h20}, {18'h00040, 8'h3b, 8'h10},
         {18'h00020, 8'h3c, 8'h80}, {18'h00010, 8'h3c, 8'h40},
         {18'h00008, 8'h40, 8'h80}, {18'h00004, 8'h40, 8'h40},
         {18'h00002, 8'h40, 8'h20}, {18'h00001, 8'h40, 8'h10},
         {18'h00000, 8'h45, 8'h00}};
      regs = '{8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h40, 8'h44, 8'h45};
      tick(16);
      aresetn <= 1;
      for (int k = 0; k < 19; k++) begin
         i = rows[k][15:8];
         e = rows[k][7:0];
         lat = i < 8'h3c;
         src(rows[k][33:16]);
         rdc(i, e);
         chk({31'h0, irq}, {31'h0, lat});
         src(18'h0);
         rdc(i, lat ? e : 8'h00);
         rdc(i, 8'h00);
         rdc(`IRQ_STATUS_IDX, lat ? 8'h01 << (i - 8'h39) : 8'h00);
         tick(2);
         chk({31'h0, irq}, 32'h0);
      end
      note("rows");
      // Regulator short still latches while its interrupt is masked
      wr(`CH2_FAULT_LATCHED_IDX, 8'h02);
      chk({30'h0, r}, {30'h0, `RESP_OKAY});
      rdc(`CH2_FAULT_LATCHED_IDX, 8'h02);
      src(18'h02000);
      src(18'h0);
      chk({31'h0, irq}, 32'h0);
      rdc(`IRQ_STATUS_IDX, 8'h00);
      rdc(`CH2_FAULT_LATCHED_IDX, 8'h03);
      rdc(`CH2_FAULT_LATCHED_IDX, 8'h02);
      wr(`CH2_FAULT_LATCHED_IDX, 8'h00);
      rdc(`CH2_FAULT_LATCHED_IDX, 8'h00);
      note("regulator mask");
      wr(`IRQ_MASK_IDX, 8'h02);
      rdc(`IRQ_MASK_IDX, 8'h02);
      src(18'h01000);
      src(18'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`IRQ_MASK_IDX, 8'h00);
      tick(3);
      chk({31'h0, irq}, 32'h1);
      rdc(`IRQ_STATUS_IDX, 8'h02);
      rdc(`HEADSET_EVENT_LATCHED_IDX, 8'h08);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      note("interrupt mask");
      rd(8'h3d);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR});
      chk(d, 32'h0);
      wr(8'h3d, 8'h00);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR});
      wr(`CH1_FAULT_LIVE_IDX, 8'hf0);
      rdc(`CH1_FAULT_LIVE_IDX, 8'h00);
      // Lane 0 disabled: the mask bit must not move
      wstrb <= 4'h0;
      wr(`CH2_FAULT_LATCHED_IDX, 8'h02);
      wstrb <= 4'h1;
      chk({30'h0, r}, {30'h0, `RESP_OKAY});
      rdc(`CH2_FAULT_LATCHED_IDX, 8'h00);
      note("refusals");
      // Mid-run reset must drop flags and writable settings alike
      wr(`IRQ_MASK_IDX, 8'h03);
      wr(`CH2_FAULT_LATCHED_IDX, 8'h02);
      src(18'h00200);
      src(18'h0);
      chk({31'h0, irq}, 32'h1);
      aresetn <= 0;
      tick(4);
      aresetn <= 1;
      chk({31'h0, irq}, 32'h0);
      for (int k = 0; k < 7; k++) begin
         rdc(regs[k], 8'h00);
      end
      note("reset");
      end_of_test();
   end
endmodule
`default_nettype wire

// ==== design/fault_interrupt_status_bank.sv ====
// Latched and live fault / interrupt status registers behind AXI4-Lite.
// Assumes fault and event inputs are asynchronous levels from analog logic.
`include "fault_status_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module fault_interrupt_status_bank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire fault_status_pkg::addr_t awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire fault_status_pkg::word_t wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire fault_status_pkg::addr_t araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output fault_status_pkg::word_t rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [1:0] ch2_output_short,
   input wire logic [1:0] ch2_driver_vgnd,
   input wire logic analog_regulator_short,
   input wire logic [2:0] headset_event,
   input wire logic [1:0] general_purpose_analog_input_cross,
   input wire logic [1:0] voice_activity_detector_event,
   input wire logic [1:0] clock_lock_event,
   input wire logic [3:0] ch1_fault,
   output logic irq
);
   import fault_status_pkg::*;

   // ==========================================================
   // Address helpers
   function automatic logic hit(input addr_t a, input logic [7:0] idx);
      hit = (a == addr_t'({idx, 2'b00}));
   endfunction

   function automatic logic mapped(input addr_t a);
      mapped = hit(a, `CH2_FAULT_LATCHED_IDX) || hit(a, `HEADSET_EVENT_LATCHED_IDX) ||
               hit(a, `THRESHOLD_VOICE_EVENT_LATCHED_IDX) ||
               hit(a, `CLOCK_LOCK_EVENT_LIVE_IDX) || hit(a, `CH1_FAULT_LIVE_IDX) ||
               hit(a, `IRQ_STATUS_IDX) || hit(a, `IRQ_MASK_IDX);
   endfunction

   // Set wins over a read clear in the same cycle
   function automatic logic [3:0] latch(input logic [3:0] cur, input logic clr,
                                         input logic [3:0] ev);
      latch = clr ? ev : (cur | ev);
   endfunction

   // ==========================================================
   // Input synchronisation
   logic [`SYNC_WIDTH-1:0] raw_in;
   logic [`SYNC_WIDTH-1:0] sync_in;
   logic [1:0] ch2_short_s;
   logic [1:0] ch2_vgnd_s;
   logic reg_short_s;
   logic [2:0] headset_s;
   logic [3:0] tv_s;
   logic [1:0] clock_lock_s;
   logic [3:0] ch1_s;

   assign raw_in = {ch2_output_short, ch2_driver_vgnd, analog_regulator_short, headset_event,
                    general_purpose_analog_input_cross, voice_activity_detector_event,
                    clock_lock_event, ch1_fault};

   pin_sync #(.WIDTH(`SYNC_WIDTH)) pin_sync_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(raw_in),
      .q(sync_in)
   );

   assign {ch2_short_s, ch2_vgnd_s, reg_short_s, headset_s, tv_s, clock_lock_s, ch1_s} = sync_in;

   // ==========================================================
   // Write channel
   wstate_t wstate_reg, wstate_next;
   addr_t waddr_reg, waddr_next;
   byte_t wbyte_reg, wbyte_next;
   logic wlane_reg, wlane_next;
   logic [1:0] bresp_reg, bresp_next;
   logic aw_take, w_take, b_take, commit;

   assign awready = (wstate_reg == W_IDLE) || (wstate_reg == W_DATA);
   assign wready = (wstate_reg == W_IDLE) || (wstate_reg == W_ADDR);
   assign bvalid = (wstate_reg == W_RESP);
   assign bresp = bresp_reg;
   assign aw_take = awvalid && awready;
   assign w_take = wvalid && wready;
   assign b_take = bvalid && bready;
   // Writes land as the response is accepted; only one write is in flight
   assign commit = b_take;

   always_comb begin
      wstate_next = wstate_reg;
      waddr_next = aw_take ? awaddr : waddr_reg;
      wbyte_next = w_take ? wdata[7:0] : wbyte_reg;
      wlane_next = w_take ? wstrb[0] : wlane_reg;
      bresp_next = aw_take ? (mapped(awaddr) ? `RESP_OKAY : `RESP_SLVERR) : bresp_reg;
      case (wstate_reg)
         W_IDLE: begin
            if (aw_take && w_take) begin
               wstate_next = W_RESP;
            end else if (aw_take) begin
               wstate_next = W_ADDR;
            end else if (w_take) begin
               wstate_next = W_DATA;
            end
         end
         W_ADDR: begin
            if (w_take) begin
               wstate_next = W_RESP;
            end
         end
         W_DATA: begin
            if (aw_take) begin
               wstate_next = W_RESP;
            end
         end
         W_RESP: begin
            if (b_take) begin
               wstate_next = W_IDLE;
            end
         end
         default: wstate_next = W_IDLE;
      endcase
      if (!aresetn) begin
         wstate_next = W_IDLE;
         waddr_next = '0;
         wbyte_next = `STATUS_RESET;
         wlane_next = 1'b0;
         bresp_next = `RESP_OKAY;
      end
   end

   always_ff @(posedge aclk) begin
      wstate_reg <= wstate_next;
      waddr_reg <= waddr_next;
      wbyte_reg <= wbyte_next;
      wlane_reg <= wlane_next;
      bresp_reg <= bresp_next;
   end

   // ==========================================================
   // Status registers
   logic [3:0] ch2_lat_reg, ch2_lat_next;
   logic reg_short_lat_reg, reg_short_lat_next;
   logic reg_mask_reg, reg_mask_next;
   logic [2:0] headset_lat_reg, headset_lat_next;
   logic [3:0] tv_lat_reg, tv_lat_next;
   logic [2:0] irq_status_reg, irq_status_next;
   logic [2:0] irq_mask_reg, irq_mask_next;
   logic irq_reg, irq_next;
   logic rd_take;
   logic [2:0] irq_event;
   logic [3:0] hs_tmp;

   assign rd_take = arvalid && arready;

   always_comb begin
      ch2_lat_next = latch(ch2_lat_reg, rd_take && hit(araddr, `CH2_FAULT_LATCHED_IDX),
                           {ch2_short_s, ch2_vgnd_s});
      reg_short_lat_next = rd_take && hit(araddr, `CH2_FAULT_LATCHED_IDX) ?
                           reg_short_s : (reg_short_lat_reg | reg_short_s);
      hs_tmp = latch({1'b0, headset_lat_reg}, rd_take &&
                     hit(araddr, `HEADSET_EVENT_LATCHED_IDX), {1'b0, headset_s});
      headset_lat_next = hs_tmp[2:0];
      tv_lat_next = latch(tv_lat_reg, rd_take &&
                          hit(araddr, `THRESHOLD_VOICE_EVENT_LATCHED_IDX), tv_s);
      // Regulator short reaches the interrupt only when unmasked
      irq_event[`IRQ_CH2_BIT] = (|{ch2_short_s, ch2_vgnd_s}) ||
                                (reg_short_s && !reg_mask_reg);
      irq_event[`IRQ_HEADSET_BIT] = |headset_s;
      irq_event[`IRQ_THRESH_VOICE_BIT] = |tv_s;
      hs_tmp = latch({1'b0, irq_status_reg}, rd_take && hit(araddr, `IRQ_STATUS_IDX),
                     {1'b0, irq_event});
      irq_status_next = hs_tmp[2:0];
      reg_mask_next = reg_mask_reg;
      irq_mask_next = irq_mask_reg;
      if (commit && wlane_reg && hit(waddr_reg, `CH2_FAULT_LATCHED_IDX)) begin
         reg_mask_next = wbyte_reg[`REG_SHORT_MASK_BIT];
      end
      if (commit && wlane_reg && hit(waddr_reg, `IRQ_MASK_IDX)) begin
         irq_mask_next = wbyte_reg[2:0];
      end
      irq_next = |(irq_status_next & ~irq_mask_next);
      if (!aresetn) begin
         ch2_lat_next = 4'h0;
         reg_short_lat_next = 1'b0;
         reg_mask_next = 1'b0;
         headset_lat_next = 3'h0;
         tv_lat_next = 4'h0;
         irq_status_next = 3'h0;
         irq_mask_next = `IRQ_MASK_RESET;
         irq_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      ch2_lat_reg <= ch2_lat_next;
      reg_short_lat_reg <= reg_short_lat_next;
      reg_mask_reg <= reg_mask_next;
      headset_lat_reg <= headset_lat_next;
      tv_lat_reg <= tv_lat_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
   end

   assign irq = irq_reg;

   // ==========================================================
   // Read channel
   logic rvalid_reg, rvalid_next;
   word_t rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   byte_t rbyte;

   assign arready = !rvalid_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   always_comb begin
      rbyte = `STATUS_RESET;
      if (hit(araddr, `CH2_FAULT_LATCHED_IDX)) begin
         rbyte = {ch2_lat_reg, 2'b00, reg_mask_reg, reg_short_lat_reg};
      end else if (hit(araddr, `HEADSET_EVENT_LATCHED_IDX)) begin
         rbyte = {4'h0, headset_lat_reg, 1'b0};
      end else if (hit(araddr, `THRESHOLD_VOICE_EVENT_LATCHED_IDX)) begin
         rbyte = {tv_lat_reg, 4'h0};
      end else if (hit(araddr, `CLOCK_LOCK_EVENT_LIVE_IDX)) begin
         rbyte = {clock_lock_s, 6'h00};
      end else if (hit(araddr, `CH1_FAULT_LIVE_IDX)) begin
         rbyte = {ch1_s, 4'h0};
      end else if (hit(araddr, `IRQ_STATUS_IDX)) begin
         rbyte = {5'h00, irq_status_reg};
      end else if (hit(araddr, `IRQ_MASK_IDX)) begin
         rbyte = {5'h00, irq_mask_reg};
      end
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
      if (rd_take) begin
         rvalid_next = 1'b1;
         rdata_next = {24'h000000, rbyte};
         rresp_next = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (!aresetn) begin
         rvalid_next = 1'b0;
         rdata_next = '0;
         rresp_next = `RESP_OKAY;
      end
   end

   always_ff @(posedge aclk) begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ch2_read;
      rd_take && hit(araddr, `CH2_FAULT_LATCHED_IDX);
   endsequence

   sequence s_mask_commit;
      commit && wlane_reg && hit(waddr_reg, `CH2_FAULT_LATCHED_IDX);
   endsequence

   a_ch2_short_latch: assert property (ch2_short_s[1] |=> ch2_lat_reg[3])
      else $error("ch2 positive short not latched");
   a_ch2_vgnd_latch: assert property (ch2_vgnd_s[0] |=> ch2_lat_reg[0])
      else $error("ch2 negative virtual ground not latched");
   a_reg_mask_write: assert property (s_mask_commit |=> reg_mask_reg == $past(wbyte_reg[1]))
      else $error("regulator mask not written");
   a_reg_short_hold: assert property (reg_short_lat_reg && !rd_take |=> reg_short_lat_reg)
      else $error("regulator short flag lost");
   a_reserved_zero: assert property (rvalid_reg |-> rdata_reg[31:8] == 24'h000000)
      else $error("unused read bits not zero");
   a_headset_latch: assert property (headset_s[2] |=> headset_lat_reg[2])
      else $error("headset insert not latched");
   a_tv_clear: assert property (rd_take && hit(araddr, `THRESHOLD_VOICE_EVENT_LATCHED_IDX)
      |=> tv_lat_reg == $past(tv_s))
      else $error("threshold flags not cleared by read");
   a_voice_hold: assert property (tv_lat_reg[1] && !rd_take |=> tv_lat_reg[1])
      else $error("voice flag lost");
   a_live_clock: assert property (rd_take && hit(araddr, `CLOCK_LOCK_EVENT_LIVE_IDX)
      |=> rdata_reg[7:6] == $past(clock_lock_s) && rvalid_reg)
      else $error("clock lock live value wrong");
   a_live_ch1: assert property (rd_take && hit(araddr, `CH1_FAULT_LIVE_IDX)
      |=> rdata_reg[7:4] == $past(ch1_s))
      else $error("ch1 live value wrong");
   a_irq_level: assert property (irq == |(irq_status_reg & ~irq_mask_reg))
      else $error("interrupt level mismatch");
   a_ch2_readclear: assert property (s_ch2_read ##1 !(|$past(ch2_short_s))
      |-> ch2_lat_reg[3:2] == 2'b00)
      else $error("ch2 short flags not self cleared");
   a_live_untouched: assert property (commit |=> rdata_reg == $past(rdata_reg) || rvalid_reg)
      else $error("read data changed by write");
endmodule
`default_nettype wire

// ==== design/fault_status_cfg.svh ====
// Constants of the fault and interrupt status bank: register indices,
// field positions, reset values and bus answers.
// Assumes inclusion by bare name from the status bank source files.
`ifndef FAULT_STATUS_CFG_SVH
`define FAULT_STATUS_CFG_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define CH2_FAULT_LATCHED_IDX 8'h39
`define HEADSET_EVENT_LATCHED_IDX 8'h3a
`define THRESHOLD_VOICE_EVENT_LATCHED_IDX 8'h3b
`define CLOCK_LOCK_EVENT_LIVE_IDX 8'h3c
`define CH1_FAULT_LIVE_IDX 8'h40
`define IRQ_STATUS_IDX 8'h44
`define IRQ_MASK_IDX 8'h45

// ==========================================================
// Field positions (lowest bit of each field)
`define CH2_SHORT_LSB 6
`define CH2_VGND_LSB 4
`define REG_SHORT_MASK_BIT 1
`define REG_SHORT_BIT 0
`define HEADSET_LSB 1
`define THRESHOLD_LSB 6
`define VOICE_LSB 4
`define CLOCK_LOCK_LSB 6
`define CH1_FAULT_LSB 4
`define IRQ_CH2_BIT 0
`define IRQ_HEADSET_BIT 1
`define IRQ_THRESH_VOICE_BIT 2

// ==========================================================
// Reset values and bus answers
`define STATUS_RESET 8'h00
`define IRQ_MASK_RESET 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define SYNC_WIDTH 18

`endif

// ==== design/fault_status_pkg.sv ====
// Types shared by the fault and interrupt status bank.
// Assumes a 12-bit AXI4-Lite byte address.
`default_nettype none
package fault_status_pkg;
   typedef logic [11:0] addr_t;
   typedef logic [7:0] byte_t;
   typedef logic [31:0] word_t;
   // Gray along idle, address held, response
   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_ADDR = 2'b01,
      W_RESP = 2'b11,
      W_DATA = 2'b10
   } wstate_t;
endpackage
`default_nettype wire

// ==== design/pin_sync.sv ====
// Two-flop synchroniser bank for asynchronous fault and event levels.
// Assumes inputs are slow levels; each bit is synchronised on its own.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] q_next;

   always_comb begin
      meta_next = aresetn ? d : '0;
      q_next = aresetn ? meta_reg : '0;
   end

   always_ff @(posedge aclk) begin
      meta_reg <= meta_next;
      q <= q_next;
   end
endmodule
`default_nettype wire
